// ### rtl/umfc_cfg.svh
// constants for the modem, flow and rs-485 control block
`ifndef UMFC_CFG_SVH
`define UMFC_CFG_SVH

// register offsets on the 4-bit register port
`define UMFC_OFF_MODEM      4'h0
`define UMFC_OFF_SCRATCH    4'h1
`define UMFC_OFF_FEATURE    4'h2
`define UMFC_OFF_MODEM_CTL  4'h3
`define UMFC_OFF_ENH_CTL    4'h4
`define UMFC_OFF_RX_TRIG    4'h5
`define UMFC_OFF_DIV_LO     4'h6
`define UMFC_OFF_DIV_HI     4'h7
`define UMFC_OFF_STATE      4'h8

// reset values
`define UMFC_RST_SCRATCH    8'hff
`define UMFC_RST_FEATURE    8'h00
`define UMFC_RST_CTL        8'h00
`define UMFC_RST_RX_TRIG    7'h38
`define UMFC_RST_DIV        16'h0010

// modem status / gate write field positions
`define UMFC_MS_CD          7
`define UMFC_MS_RI          6
`define UMFC_MS_DSR         5
`define UMFC_MS_CTS         4
`define UMFC_MS_TURN_HI     7
`define UMFC_MS_TURN_LO     4
`define UMFC_MS_TX_DIS      3
`define UMFC_MS_RX_DIS      2

// modem control bits
`define UMFC_MC_DTR         0
`define UMFC_MC_RTS         1
`define UMFC_MC_SEL         2
`define UMFC_MC_OP2         3
`define UMFC_MC_LOOP        4

// enhanced control bits
`define UMFC_EC_MSI_EN      0
`define UMFC_EC_ENH_EN      4
`define UMFC_EC_AUTO_RTS    6
`define UMFC_EC_AUTO_CTS    7

// feature control fields
`define UMFC_FC_TBL_HI      7
`define UMFC_FC_TBL_LO      6
`define UMFC_FC_RS485       5
`define UMFC_FC_IR_POL      4
`define UMFC_FC_HYS_HI      3

// trigger level tables a..c, four levels each, low to high
`define UMFC_TBL_A          {7'd1, 7'd4, 7'd8, 7'd14}
`define UMFC_TBL_B          {7'd8, 7'd16, 7'd24, 7'd28}
`define UMFC_TBL_C          {7'd8, 7'd16, 7'd56, 7'd60}
`define UMFC_FIFO_TOP       7'd64

`endif

// ### rtl/umfc_pkg.sv
// types for the modem, flow and rs-485 control block
package umfc_pkg;

	// rs-485 direction states
	typedef enum logic [1:0] {
		UMFC_DIR_RX    = 2'b00,
		UMFC_DIR_TX    = 2'b01,
		UMFC_DIR_DELAY = 2'b10
	} umfc_dir_t;

	// trigger table select
	typedef enum logic [1:0] {
		UMFC_TBL_A = 2'b00,
		UMFC_TBL_B = 2'b01,
		UMFC_TBL_C = 2'b10,
		UMFC_TBL_D = 2'b11
	} umfc_tbl_t;

endpackage

// ### rtl/umfc_ctrl.sv
// modem status, line gating, rs-485 direction and rts/dtr hysteresis
//
// Summary of operation
// - with auto cts and rts/cts pair, high cts# stops tx after current char
// - status bit 4 is inverted cts#, or the rts control bit in loopback
// - delta cd flag sets on any cd# change; raises modem irq if enabled
// - delta ri flag sets only on ri# low-to-high; raises modem irq
// - delta dsr flag sets on any dsr# change; raises modem irq
// - delta cts flag sets on any cts# change; raises modem irq
// - upper write nibble sets 0..15 bit-time turn-around before rts# drops
// - turn-around writes take effect only with enhanced enable set
// - transmitter disable stops sending after the current char until cleared; resets to 0
// - receiver disable blocks at once, even mid-char; a clear waits for char end; resets to 0
// - receive fifo stays readable whether or not receiver is disabled
// - scratch register holds any write and resets to all ones
// - two feature bits select trigger table a, b, c or d
// - tables a-c: flow drops at next level above, returns next below
// - rs-485: rts# low after last stop bit, high on byte load
// - rs-485 moves tx interrupt from holding-empty to shift-empty
// - infrared receive polarity bit inverts encoded rx data when 1
// - hysteresis field used only in table d; zero means next level
// - hysteresis codes map to fixed plus/minus character counts

`timescale 1ns/10ps

`include "umfc_cfg.svh"

module umfc_ctrl (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	// register port
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// modem lines
	input  wire logic       cts_n,
	input  wire logic       dsr_n,
	input  wire logic       cd_n,
	input  wire logic       ri_n,
	output logic            rts_n,
	output logic            dtr_n,
	// transmitter side
	input  wire logic       tx_load,
	input  wire logic       tx_char_done,
	input  wire logic       tx_busy,
	input  wire logic       tx_fifo_empty,
	output logic            tx_go,
	output logic            tx_irq_event,
	// receiver side
	input  wire logic       rx_busy,
	input  wire logic [6:0] rx_level,
	input  wire logic       ir_rx_in,
	output logic            rx_go,
	output logic            ir_rx_data,
	output logic            rx_fifo_read_ok,
	// modem status interrupt
	output logic            modem_irq
);

	////////////////////////////////////////////////////////////////////
	// state
	logic [7:0]  scratch_r;
	logic [7:0]  feature_r;
	logic [7:0]  modem_ctl_r;
	logic [7:0]  enh_ctl_r;
	logic [6:0]  rx_trig_r;
	logic [15:0] bit_div_r;
	logic [3:0]  turn_r;
	logic        tx_dis_r;
	logic        rx_dis_r;
	logic        rx_gate_r;
	logic [3:0]  delta_r;
	logic [3:0]  line_prev_r;
	logic        flow_halt_r;
	logic [15:0] div_cnt_r;
	logic [3:0]  bit_cnt_r;
	logic        ir_rx_r;
	umfc_pkg::umfc_dir_t dir_r;
	umfc_pkg::umfc_dir_t dir_nxt;

	logic [3:0]  line_now;
	logic [3:0]  delta_set;
	logic        loop;
	logic        rs485;
	logic        wr_en;
	logic        rd_en;
	logic        bit_tick;
	logic [6:0]  up_lvl;
	logic [6:0]  dn_lvl;
	logic [6:0]  hys;
	logic        flow_on_rts;

	assign wr_en = reg_wr & clk_en;
	assign rd_en = reg_rd & clk_en;
	assign loop  = modem_ctl_r[`UMFC_MC_LOOP];
	assign rs485 = feature_r[`UMFC_FC_RS485];

	////////////////////////////////////////////////////////////////////
	// helpers

	// hysteresis code to character count
	function automatic logic [6:0] hys_of(input logic [3:0] code);
		case (code)
			4'h0: hys_of = 7'd0;
			4'h1: hys_of = 7'd4;
			4'h2: hys_of = 7'd6;
			4'h3: hys_of = 7'd8;
			4'h4: hys_of = 7'd8;
			4'h5: hys_of = 7'd16;
			4'h6: hys_of = 7'd24;
			4'h7: hys_of = 7'd32;
			4'h8: hys_of = 7'd40;
			4'h9: hys_of = 7'd44;
			4'ha: hys_of = 7'd48;
			4'hb: hys_of = 7'd52;
			4'hc: hys_of = 7'd12;
			4'hd: hys_of = 7'd20;
			4'he: hys_of = 7'd28;
			4'hf: hys_of = 7'd36;
			default: hys_of = 7'd0;
		endcase
	endfunction

	// pick next level above (up=1) or below the trigger in a table
	function automatic logic [6:0] next_lvl(input logic [27:0] tbl,
		input logic [6:0] trig, input logic up);
		logic [6:0] res;
		logic [6:0] lv;
		res = up ? `UMFC_FIFO_TOP : 7'd0;
		for (int i = 0; i < 4; i++) begin
			lv = tbl[i*7 +: 7];
			if (up && lv > trig && lv < res)
				res = lv;
			if (!up && lv < trig && lv > res)
				res = lv;
		end
		next_lvl = res;
	endfunction

	////////////////////////////////////////////////////////////////////
	// modem line status, inverted pins or loopback control bits
	always_comb begin
		line_now[3] = loop ? modem_ctl_r[`UMFC_MC_OP2] : ~cd_n;
		line_now[2] = loop ? modem_ctl_r[`UMFC_MC_SEL] : ~ri_n;
		line_now[1] = loop ? modem_ctl_r[`UMFC_MC_DTR] : ~dsr_n;
		line_now[0] = loop ? modem_ctl_r[`UMFC_MC_RTS] : ~cts_n;
	end

	// change detection; ri only on pin rising, i.e. status falling
	always_comb begin
		delta_set[3] = line_now[3] ^ line_prev_r[3];
		delta_set[2] = line_prev_r[2] & ~line_now[2];
		delta_set[1] = line_now[1] ^ line_prev_r[1];
		delta_set[0] = line_now[0] ^ line_prev_r[0];
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			line_prev_r <= 4'h0;
		else if (clk_en)
			line_prev_r <= line_now;
	end

	// read clears, but a change in the read cycle still lands
	always_ff @(posedge clk) begin
		if (!rst_n)
			delta_r <= 4'h0;
		else if (rd_en && reg_addr == `UMFC_OFF_MODEM)
			delta_r <= delta_set;
		else if (clk_en)
			delta_r <= delta_r | delta_set;
	end

	assign modem_irq = enh_ctl_r[`UMFC_EC_MSI_EN] & (|delta_r);

	////////////////////////////////////////////////////////////////////
	// register writes
	always_ff @(posedge clk) begin
		if (!rst_n)
			scratch_r <= `UMFC_RST_SCRATCH;
		else if (wr_en && reg_addr == `UMFC_OFF_SCRATCH)
			scratch_r <= reg_wdata;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			feature_r   <= `UMFC_RST_FEATURE;
			modem_ctl_r <= `UMFC_RST_CTL;
			enh_ctl_r   <= `UMFC_RST_CTL;
			rx_trig_r   <= `UMFC_RST_RX_TRIG;
			bit_div_r   <= `UMFC_RST_DIV;
		end else if (wr_en) begin
			case (reg_addr)
				`UMFC_OFF_FEATURE:   feature_r   <= reg_wdata;
				`UMFC_OFF_MODEM_CTL: modem_ctl_r <= reg_wdata;
				`UMFC_OFF_ENH_CTL:   enh_ctl_r   <= reg_wdata;
				`UMFC_OFF_RX_TRIG:   rx_trig_r   <= reg_wdata[6:0];
				`UMFC_OFF_DIV_LO:    bit_div_r[7:0]  <= reg_wdata;
				`UMFC_OFF_DIV_HI:    bit_div_r[15:8] <= reg_wdata;
				default: ;
			endcase
		end
	end

	// gate bits always writable; turn-around only when enhanced
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			turn_r   <= 4'h0;
			tx_dis_r <= 1'b0;
			rx_dis_r <= 1'b0;
		end else if (wr_en && reg_addr == `UMFC_OFF_MODEM) begin
			tx_dis_r <= reg_wdata[`UMFC_MS_TX_DIS];
			rx_dis_r <= reg_wdata[`UMFC_MS_RX_DIS];
			if (enh_ctl_r[`UMFC_EC_ENH_EN])
				turn_r <= reg_wdata[`UMFC_MS_TURN_HI:`UMFC_MS_TURN_LO];
		end
	end

	////////////////////////////////////////////////////////////////////
	// register read, data in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else if (rd_en) begin
			case (reg_addr)
				`UMFC_OFF_MODEM:     reg_rdata <= {line_now, delta_r};
				`UMFC_OFF_SCRATCH:   reg_rdata <= scratch_r;
				`UMFC_OFF_FEATURE:   reg_rdata <= feature_r;
				`UMFC_OFF_MODEM_CTL: reg_rdata <= modem_ctl_r;
				`UMFC_OFF_ENH_CTL:   reg_rdata <= enh_ctl_r;
				`UMFC_OFF_RX_TRIG:   reg_rdata <= {1'b0, rx_trig_r};
				`UMFC_OFF_DIV_LO:    reg_rdata <= bit_div_r[7:0];
				`UMFC_OFF_DIV_HI:    reg_rdata <= bit_div_r[15:8];
				`UMFC_OFF_STATE:     reg_rdata <= {2'b00, dir_r,
					flow_halt_r, rx_gate_r, tx_go, tx_dis_r};
				default:             reg_rdata <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// transmitter gating: the shifter only starts a char on tx_go,
	// so a char already out always completes
	assign flow_on_rts = ~modem_ctl_r[`UMFC_MC_SEL];
	assign tx_go = ~tx_dis_r
		& ~(enh_ctl_r[`UMFC_EC_AUTO_CTS] & (flow_on_rts ? cts_n : dsr_n));

	// tx interrupt source: holding empty or, in rs-485, shifter empty too
	assign tx_irq_event = rs485 ? (tx_fifo_empty & ~tx_busy)
		: tx_fifo_empty;

	////////////////////////////////////////////////////////////////////
	// receiver gating: a clear seen mid-char waits for the char end
	always_ff @(posedge clk) begin
		if (!rst_n)
			rx_gate_r <= 1'b1;
		else if (clk_en && !rx_busy)
			rx_gate_r <= ~rx_dis_r;
	end
	// a disable blocks at once, mid-char too; the gate flop delays only a clear
	assign rx_go = rx_gate_r & ~rx_dis_r;
	assign rx_fifo_read_ok = 1'b1;

	// infrared polarity; registered so the data output is a flop
	always_ff @(posedge clk) begin
		if (!rst_n)
			ir_rx_r <= 1'b0;
		else if (clk_en)
			ir_rx_r <= ir_rx_in ^ feature_r[`UMFC_FC_IR_POL];
	end
	assign ir_rx_data = ir_rx_r;

	////////////////////////////////////////////////////////////////////
	// hysteresis thresholds from the selected trigger table
	always_comb begin
		hys = hys_of(feature_r[`UMFC_FC_HYS_HI:0]);
		case (umfc_pkg::umfc_tbl_t'(feature_r[`UMFC_FC_TBL_HI:`UMFC_FC_TBL_LO]))
			umfc_pkg::UMFC_TBL_A: begin
				up_lvl = next_lvl(`UMFC_TBL_A, rx_trig_r, 1'b1);
				dn_lvl = next_lvl(`UMFC_TBL_A, rx_trig_r, 1'b0);
			end
			umfc_pkg::UMFC_TBL_B: begin
				up_lvl = next_lvl(`UMFC_TBL_B, rx_trig_r, 1'b1);
				dn_lvl = next_lvl(`UMFC_TBL_B, rx_trig_r, 1'b0);
			end
			umfc_pkg::UMFC_TBL_D: begin
				// code zero falls back to next-level behaviour
				if (hys == 7'd0) begin
					up_lvl = next_lvl(`UMFC_TBL_C, rx_trig_r, 1'b1);
					dn_lvl = next_lvl(`UMFC_TBL_C, rx_trig_r, 1'b0);
				end else begin
					up_lvl = (rx_trig_r + hys > `UMFC_FIFO_TOP) ?
						`UMFC_FIFO_TOP : 7'(rx_trig_r + hys);
					dn_lvl = (rx_trig_r > hys) ?
						7'(rx_trig_r - hys) : 7'd0;
				end
			end
			default: begin
				up_lvl = next_lvl(`UMFC_TBL_C, rx_trig_r, 1'b1);
				dn_lvl = next_lvl(`UMFC_TBL_C, rx_trig_r, 1'b0);
			end
		endcase
	end

	// halt far end at upper level, release below lower level
	always_ff @(posedge clk) begin
		if (!rst_n)
			flow_halt_r <= 1'b0;
		else if (clk_en) begin
			if (rx_level >= up_lvl)
				flow_halt_r <= 1'b1;
			else if (rx_level < dn_lvl)
				flow_halt_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// bit-time tick from the programmed divisor, zero acts as one
	assign bit_tick = (div_cnt_r == 16'h0000);

	always_ff @(posedge clk) begin
		if (!rst_n)
			div_cnt_r <= 16'h0000;
		else if (clk_en) begin
			if (dir_r != umfc_pkg::UMFC_DIR_DELAY || bit_tick)
				div_cnt_r <= (bit_div_r == 16'h0000) ? 16'h0000 :
					16'(bit_div_r - 16'h0001);
			else
				div_cnt_r <= 16'(div_cnt_r - 16'h0001);
		end
	end

	// rs-485 direction: high while sending, low after turn-around
	always_comb begin
		dir_nxt = dir_r;
		case (dir_r)
			umfc_pkg::UMFC_DIR_RX:
				if (tx_load)
					dir_nxt = umfc_pkg::UMFC_DIR_TX;
			umfc_pkg::UMFC_DIR_TX:
				if (tx_char_done && tx_fifo_empty && !tx_load)
					dir_nxt = (turn_r == 4'h0) ? umfc_pkg::UMFC_DIR_RX
						: umfc_pkg::UMFC_DIR_DELAY;
			umfc_pkg::UMFC_DIR_DELAY:
				if (tx_load)
					dir_nxt = umfc_pkg::UMFC_DIR_TX;
				else if (bit_tick && bit_cnt_r == 4'h1)
					dir_nxt = umfc_pkg::UMFC_DIR_RX;
			default: dir_nxt = umfc_pkg::UMFC_DIR_RX;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			dir_r <= umfc_pkg::UMFC_DIR_RX;
		else if (clk_en)
			dir_r <= dir_nxt;
	end

	// remaining bit times of the turn-around
	always_ff @(posedge clk) begin
		if (!rst_n)
			bit_cnt_r <= 4'h0;
		else if (clk_en) begin
			if (dir_r != umfc_pkg::UMFC_DIR_DELAY)
				bit_cnt_r <= turn_r;
			else if (bit_tick)
				bit_cnt_r <= 4'(bit_cnt_r - 4'h1);
		end
	end

	////////////////////////////////////////////////////////////////////
	// modem outputs; auto flow only drives when the bit asserts the line
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rts_n <= 1'b1;
			dtr_n <= 1'b1;
		end else if (clk_en) begin
			if (rs485)
				rts_n <= (dir_nxt != umfc_pkg::UMFC_DIR_RX);
			else if (enh_ctl_r[`UMFC_EC_AUTO_RTS] && flow_on_rts)
				rts_n <= ~modem_ctl_r[`UMFC_MC_RTS] | flow_halt_r;
			else
				rts_n <= ~modem_ctl_r[`UMFC_MC_RTS];
			if (enh_ctl_r[`UMFC_EC_AUTO_RTS] && !flow_on_rts)
				dtr_n <= ~modem_ctl_r[`UMFC_MC_DTR] | flow_halt_r;
			else
				dtr_n <= ~modem_ctl_r[`UMFC_MC_DTR];
		end
	end

endmodule

// ### testbench/umfc_ctrl_checker.sv
// assertion checker for the modem, flow and rs-485 control block
`timescale 1ns/10ps
`include "umfc_cfg.svh"

module umfc_ctrl_checker (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       clk_en,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// line side
	input wire logic       cts_n,
	input wire logic       rts_n,
	input wire logic       tx_load,
	input wire logic       tx_go,
	input wire logic       rx_busy,
	input wire logic       rx_go,
	input wire logic       ir_rx_in,
	input wire logic       ir_rx_data,
	input wire logic       rx_fifo_read_ok,
	input wire logic       modem_irq
);
	logic [7:0] gate_r;
	logic [7:0] feat_r;
	logic [7:0] mctl_r;
	logic [7:0] enh_r;

	////////////////////////////////////////////////////////////
	// shadow of the control registers, written on the block's edges
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gate_r <= 8'h00;
			feat_r <= 8'h00;
			mctl_r <= 8'h00;
			enh_r  <= 8'h00;
		end else if (clk_en && reg_wr) begin
			if (reg_addr == `UMFC_OFF_MODEM) gate_r <= reg_wdata;
			if (reg_addr == `UMFC_OFF_FEATURE) feat_r <= reg_wdata;
			if (reg_addr == `UMFC_OFF_MODEM_CTL) mctl_r <= reg_wdata;
			if (reg_addr == `UMFC_OFF_ENH_CTL) enh_r <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence status_rd_s;
		clk_en && reg_rd && reg_addr == `UMFC_OFF_MODEM;
	endsequence

	sequence cts_turn_s;
		clk_en && $changed(cts_n) && enh_r[`UMFC_EC_MSI_EN];
	endsequence

	tx_hold_a: assert property (gate_r[3] |-> !tx_go)
		else $error("transmitter runs while disabled");
	cts_halt_a: assert property (enh_r[7] && !mctl_r[2] && cts_n
		&& $stable(cts_n) |-> !tx_go)
		else $error("transmitter runs with cts released");
	rx_stop_a: assert property (gate_r[2] && !rx_busy
		&& !$past(rx_busy) && !$past(rx_busy, 2) |-> !rx_go)
		else $error("receiver open while disabled and idle");
	ir_pol_a: assert property ($past(clk_en) && $past(rst_n)
		|-> ir_rx_data == ($past(ir_rx_in) ^ $past(feat_r[4])))
		else $error("ir receive polarity wrong");
	read_ok_a: assert property (rx_fifo_read_ok)
		else $error("rx fifo not readable");
	dir_load_a: assert property (feat_r[5] && clk_en && tx_load |=> rts_n)
		else $error("direction not transmit after load");
	cts_delta_a: assert property (cts_turn_s |=> modem_irq)
		else $error("cts change gave no modem irq");
	irq_mask_a: assert property (!enh_r[0] |-> !modem_irq)
		else $error("modem irq while masked");
	cts_status_a: assert property (status_rd_s ##0 (!mctl_r[4]
		&& $stable(cts_n)) |=> reg_rdata[4] == !$past(cts_n))
		else $error("cts status bit wrong");
endmodule

bind umfc_ctrl umfc_ctrl_checker i_umfc_ctrl_checker (
	.clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .cts_n, .rts_n, .tx_load, .tx_go, .rx_busy, .rx_go,
	.ir_rx_in, .ir_rx_data, .rx_fifo_read_ok, .modem_irq
);

// ### testbench/umfc_modem_model.sv
// behavioural modem partner driving the four status lines
`timescale 1ns/10ps

module umfc_modem_model (
	// clock
	input wire logic       clk,
	// wanted levels {cd, ri, dsr, cts}, 1 = high (released)
	input wire logic [3:0] want,
	// modem lines toward the block
	output logic           cts_n,
	output logic           dsr_n,
	output logic           cd_n,
	output logic           ri_n
);
	logic [3:0] pins_r = 4'hf;

	// lines follow a request one edge late; idle is high, not asserted
	always @(posedge clk) begin
		pins_r <= want;
	end
	assign {cd_n, ri_n, dsr_n, cts_n} = pins_r;
endmodule

// ### testbench/umfc_ctrl_tb.sv
// self-checking bench for the modem, flow and rs-485 control block
`timescale 1ns/10ps
`include "umfc_cfg.svh"

module umfc_ctrl_tb;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       clk_en = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [3:0] want = 4'hf;
	logic       cts_n, dsr_n, cd_n, ri_n, rts_n, dtr_n;
	logic       tx_load = 1'b0;
	logic       tx_char_done = 1'b0;
	logic       tx_busy = 1'b0;
	logic       tx_fifo_empty = 1'b1;
	logic       rx_busy = 1'b0;
	logic [6:0] rx_level = 7'h00;
	logic       ir_rx_in = 1'b0;
	logic       tx_go, tx_irq_event, rx_go, ir_rx_data;
	logic       rx_fifo_read_ok, modem_irq;
	int         miscompares = 0;
	int         checked = 0;

	////////////////////////////////////////////////////////////
	umfc_ctrl i_umfc_ctrl (
		.clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .cts_n, .dsr_n, .cd_n, .ri_n, .rts_n, .dtr_n,
		.tx_load, .tx_char_done, .tx_busy, .tx_fifo_empty, .tx_go,
		.tx_irq_event, .rx_busy, .rx_level, .ir_rx_in, .rx_go,
		.ir_rx_data, .rx_fifo_read_ok, .modem_irq
	);
	umfc_modem_model i_umfc_modem_model (
		.clk, .want, .cts_n, .dsr_n, .cd_n, .ri_n
	);

	// 250 MHz clock
	initial begin
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// strobes lowered on the next edge, so back-to-back calls never clash
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		v = reg_rdata;
	endtask

	task automatic lvl(input logic [6:0] l, input logic e);
		@(posedge clk);
		rx_level <= l;
		repeat (3) @(negedge clk);
		chk(rts_n, e);
	endtask

	// one transmit burst in rs-485 mode; n counts cycles to receive
	task automatic dir_run(output int n);
		@(posedge clk);
		tx_load       <= 1'b1;
		tx_fifo_empty <= 1'b0;
		tx_busy       <= 1'b1;
		@(posedge clk);
		tx_load       <= 1'b0;
		tx_fifo_empty <= 1'b1;
		@(negedge clk);
		chk(rts_n, 1'b1);
		chk(tx_irq_event, 1'b0);
		@(posedge clk);
		tx_char_done <= 1'b1;
		tx_busy      <= 1'b0;
		@(posedge clk);
		tx_char_done <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (rts_n !== 1'b0 && n < 200);
	endtask

	////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [7:0] v;
		rd(`UMFC_OFF_SCRATCH, v);
		chk(v, 8'hff);
		wr(`UMFC_OFF_SCRATCH, 8'h5a);
		wr(4'h9, 8'h33);
		rd(`UMFC_OFF_SCRATCH, v);
		chk(v, 8'h5a);
		rd(4'h9, v);
		chk(v, 8'h00);
		@(posedge clk);
		ir_rx_in <= 1'b1;
		wr(`UMFC_OFF_FEATURE, 8'hd7);
		// polarity lands at the write edge, the data flop one edge later
		repeat (2) @(negedge clk);
		chk(ir_rx_data, 1'b0);
		rd(`UMFC_OFF_FEATURE, v);
		chk(v, 8'hd7);
		wr(`UMFC_OFF_FEATURE, 8'h00);
		repeat (2) @(negedge clk);
		chk(ir_rx_data, 1'b1);
	endtask

	task automatic t_modem();
		logic [7:0] v;
		logic [3:0] d;
		wr(`UMFC_OFF_ENH_CTL, 8'h01);
		rd(`UMFC_OFF_MODEM, v);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			want[k] <= 1'b0;
			d = (k == 2) ? 4'h0 : 4'(1 << k);
			repeat (4) @(negedge clk);
			chk(modem_irq, |d);
			rd(`UMFC_OFF_MODEM, v);
			chk(v, {~want, d});
			rd(`UMFC_OFF_MODEM, v);
			chk(v, {~want, 4'h0});
			@(posedge clk);
			want[k] <= 1'b1;
			repeat (4) @(negedge clk);
			rd(`UMFC_OFF_MODEM, v);
			chk(v, {~want, 4'(1 << k)});
		end
		wr(`UMFC_OFF_MODEM_CTL, 8'h12);
		rd(`UMFC_OFF_MODEM, v);
		chk(v[7:4], 4'h1);
		wr(`UMFC_OFF_MODEM_CTL, 8'h00);
		wr(`UMFC_OFF_ENH_CTL, 8'h00);
		@(posedge clk);
		want[0] <= 1'b0;
		repeat (4) @(negedge clk);
		chk(modem_irq, 1'b0);
		@(posedge clk);
		want[0] <= 1'b1;
		rd(`UMFC_OFF_MODEM, v);
	endtask

	task automatic t_gate();
		wr(`UMFC_OFF_MODEM, 8'h08);
		@(negedge clk);
		chk(tx_go, 1'b0);
		wr(`UMFC_OFF_MODEM, 8'h00);
		@(negedge clk);
		chk(tx_go, 1'b1);
		@(posedge clk);
		rx_busy <= 1'b1;
		wr(`UMFC_OFF_MODEM, 8'h04);
		@(posedge clk);
		rx_busy <= 1'b0;
		repeat (3) @(negedge clk);
		chk(rx_go, 1'b0);
		chk(rx_fifo_read_ok, 1'b1);
		wr(`UMFC_OFF_MODEM, 8'h00);
		// the idle gate reopens one edge after the clear
		repeat (2) @(negedge clk);
		chk(rx_go, 1'b1);
		wr(`UMFC_OFF_ENH_CTL, 8'h80);
		@(negedge clk);
		chk(tx_go, 1'b0);
		@(posedge clk);
		want[0] <= 1'b0;
		repeat (3) @(negedge clk);
		chk(tx_go, 1'b1);
		@(posedge clk);
		want[0] <= 1'b1;
		wr(`UMFC_OFF_ENH_CTL, 8'h00);
	endtask

	task automatic t_turn();
		int n0;
		int n3;
		wr(`UMFC_OFF_FEATURE, 8'h20);
		wr(`UMFC_OFF_MODEM, 8'h30);
		dir_run(n0);
		wr(`UMFC_OFF_ENH_CTL, 8'h10);
		wr(`UMFC_OFF_MODEM, 8'h30);
		wr(`UMFC_OFF_DIV_LO, 8'h02);
		dir_run(n3);
		chk(8'(n3 - n0), 8'h06);
		@(posedge clk);
		tx_busy <= 1'b1;
		wr(`UMFC_OFF_FEATURE, 8'h00);
		@(negedge clk);
		chk(tx_irq_event, 1'b1);
		@(posedge clk);
		tx_busy <= 1'b0;
		wr(`UMFC_OFF_MODEM, 8'h00);
	endtask

	// hysteresis codes; trigger chosen so the lower threshold stays in range, the upper one may clamp at 64
	task automatic t_flow();
		int h [16] = '{0, 4, 6, 8, 8, 16, 24, 32,
			40, 44, 48, 52, 12, 20, 28, 36};
		int t;
		int u;
		wr(`UMFC_OFF_MODEM_CTL, 8'h02);
		wr(`UMFC_OFF_ENH_CTL, 8'h40);
		wr(`UMFC_OFF_RX_TRIG, 8'h08);
		wr(`UMFC_OFF_FEATURE, 8'h05);
		lvl(7'd13, 1'b0);
		lvl(7'd14, 1'b1);
		lvl(7'd3, 1'b0);
		// table c at trigger 56: drop at 60, back below 16
		wr(`UMFC_OFF_RX_TRIG, 8'h38);
		wr(`UMFC_OFF_FEATURE, 8'h80);
		lvl(7'd59, 1'b0);
		lvl(7'd60, 1'b1);
		lvl(7'd16, 1'b1);
		lvl(7'd15, 1'b0);
		// table b at trigger 16: drop at 24, back below 8
		wr(`UMFC_OFF_RX_TRIG, 8'h10);
		wr(`UMFC_OFF_FEATURE, 8'h40);
		lvl(7'd23, 1'b0);
		lvl(7'd24, 1'b1);
		lvl(7'd8, 1'b1);
		lvl(7'd7, 1'b0);
		for (int c = 1; c < 16; c++) begin
			t = (h[c] < 32) ? 32 : 60;
			u = (t + h[c] > 64) ? 64 : t + h[c];
			wr(`UMFC_OFF_RX_TRIG, 8'(t));
			wr(`UMFC_OFF_FEATURE, 8'hc0 | 8'(c));
			lvl(7'(u - 1), 1'b0);
			lvl(7'(u), 1'b1);
			lvl(7'(t - h[c]), 1'b1);
			lvl(7'(t - h[c] - 1), 1'b0);
		end
		// dtr/dsr pair: flow moves to dtr_n, rts_n follows its bit
		wr(`UMFC_OFF_MODEM_CTL, 8'h05);
		repeat (2) @(negedge clk);
		chk(dtr_n, 1'b0);
		lvl(7'd64, 1'b1);
		chk(dtr_n, 1'b1);
	endtask

	////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_modem();
		t_gate();
		t_turn();
		t_flow();
		complete_run();
	end

	// watchdog, well above the under one thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		complete_run();
	end
endmodule
